// ### bench/pms_checker_props.sv
`timescale 1ns/1ps
// Watches the sequencer's mode outputs against its supply and command inputs
module pms_checker
  import pms_pkg::*;
#(
  parameter int STARTUP_CYC = 20
) (
  // Clock and reset
  input wire logic       sys_clk_i,
  input wire logic       nrst_i,
  // Supplies and register port
  input wire logic       analog_supply_i,
  input wire logic       io_supply_level_i,
  input wire logic       reg_wr_i,
  input wire logic [1:0] reg_sel_i,
  input wire logic [3:0] reg_wdata_i,
  input wire logic [3:0] reg_rdata_o,
  // Mode controls
  input wire logic       serial_enable_o,
  input wire logic       serial_reset_o,
  input wire logic       boost_enable_o,
  input wire logic [3:0] boost_level_o,
  input wire logic [3:0] dac_enable_o,
  input wire logic [3:0] out_hiz_o,
  input wire logic [1:0] power_state_o
);
  localparam int SU_MAX = STARTUP_CYC + 6;
  // Power-state write strobe
  logic pw;
  assign pw = reg_wr_i && reg_sel_i == SEL_POWER;
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!nrst_i);

  a_hiz_mirror: assert property (out_hiz_o == ~dac_enable_o)
    else $error("output high impedance not inverse of enables");
  a_shutdown_off: assert property (!serial_enable_o |->
    !boost_enable_o && serial_reset_o && out_hiz_o == 4'hF)
    else $error("shutdown outputs not off");
  a_io_low_shut: assert property (!io_supply_level_i [*8] |-> !serial_enable_o)
    else $error("io supply low did not shut down");
  a_startup_shape: assert property (serial_enable_o && power_state_o == PWR_STARTUP
    |-> boost_enable_o && serial_reset_o && dac_enable_o == 4'h0)
    else $error("startup outputs wrong");
  a_startup_ends: assert property ($rose(serial_enable_o)
    |-> ##[1:SU_MAX] power_state_o == PWR_ACTIVE)
    else $error("startup did not reach active in time");
  a_lowpower_quiet: assert property (power_state_o == PWR_LOWPOWER
    |-> serial_enable_o && !boost_enable_o && out_hiz_o == 4'hF)
    else $error("low power outputs wrong");
  a_lp_exit_cmd: assert property (power_state_o == PWR_LOWPOWER && !pw
    |=> power_state_o != PWR_ACTIVE)
    else $error("left low power without command");
  a_lp_enter: assert property (power_state_o == PWR_ACTIVE && pw
    && reg_wdata_i[1:0] == PWR_LOWPOWER |=> power_state_o == PWR_LOWPOWER)
    else $error("low power command not taken");
  a_cmd_restart: assert property (power_state_o != PWR_STARTUP && pw
    && reg_wdata_i[1:0] == PWR_STARTUP |=> power_state_o == PWR_STARTUP
    && boost_level_o == BOOST_LEVEL_RST)
    else $error("restart command not taken");

  c_lowpower: cover property (power_state_o == PWR_LOWPOWER);
  c_startup: cover property ($rose(serial_enable_o));
  c_restart: cover property (pw && reg_wdata_i[1:0] == PWR_STARTUP);
endmodule : pms_checker

bind pms_power_mode_sequencer pms_checker #(.STARTUP_CYC(STARTUP_CYC)) u_chk (
  .sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .analog_supply_i(analog_supply_i),
  .io_supply_level_i(io_supply_level_i), .reg_wr_i(reg_wr_i), .reg_sel_i(reg_sel_i),
  .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o), .serial_enable_o(serial_enable_o),
  .serial_reset_o(serial_reset_o), .boost_enable_o(boost_enable_o),
  .boost_level_o(boost_level_o), .dac_enable_o(dac_enable_o), .out_hiz_o(out_hiz_o),
  .power_state_o(power_state_o));

// ### bench/pms_host_model.sv
`timescale 1ns/1ps
// Serial front-end host: one-cycle register writes and read selects
module pms_host_model (
  // Clock
  input  wire logic       sys_clk_i,
  // Register port toward the sequencer
  output logic            reg_wr_o,
  output logic [1:0]      reg_sel_o,
  output logic [3:0]      reg_wdata_o
);
  initial
  begin
    reg_wr_o    = 1'b0;
    reg_sel_o   = 2'h0;
    reg_wdata_o = 4'h0;
  end
  // Strobe one write; data is scrambled once released
  task automatic send_write(input logic [1:0] sel, input logic [3:0] data);
    @(negedge sys_clk_i);
    reg_wr_o    = 1'b1;
    reg_sel_o   = sel;
    reg_wdata_o = data;
    @(negedge sys_clk_i);
    reg_wr_o    = 1'b0;
    reg_wdata_o = ~data;
    @(negedge sys_clk_i);
  endtask : send_write
  // Select a register and wait for its registered read data
  task automatic select(input logic [1:0] sel);
    @(negedge sys_clk_i);
    reg_sel_o = sel;
    @(negedge sys_clk_i);
  endtask : select
endmodule : pms_host_model

// ### bench/tb_top.sv
`timescale 1ns/1ps
// Self-checking bench for the power mode sequencer
module tb_top;
  import pms_pkg::*;
  localparam int SU = 36;
  logic        clk;
  logic        nrst;
  logic        ana;
  logic        io;
  logic        wr;
  logic [1:0]  sel;
  logic [3:0]  wdata;
  logic [3:0]  rdata;
  logic        ser_en;
  logic        ser_rst;
  logic        bst_en;
  logic [3:0]  lvl;
  logic [3:0]  en;
  logic [3:0]  hiz;
  logic [1:0]  ps;
  logic [63:0] seed;
  logic [3:0]  en_v;
  logic [3:0]  lvl_v;
  int          err_count;
  int          checked;
  int          n;

  pms_power_mode_sequencer #(.STARTUP_CYC(SU)) u_dut (.sys_clk_i(clk), .nrst_i(nrst),
    .analog_supply_i(ana), .io_supply_level_i(io), .reg_wr_i(wr), .reg_sel_i(sel),
    .reg_wdata_i(wdata), .reg_rdata_o(rdata), .serial_enable_o(ser_en),
    .serial_reset_o(ser_rst), .boost_enable_o(bst_en), .boost_level_o(lvl),
    .dac_enable_o(en), .out_hiz_o(hiz), .power_state_o(ps));
  pms_host_model u_host (.sys_clk_i(clk), .reg_wr_o(wr), .reg_sel_o(sel), .reg_wdata_o(wdata));

  // Clock generation
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  function automatic logic [63:0] xorshift(input logic [63:0] s);
    logic [63:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 7);
    return x ^ (x << 17);
  endfunction : xorshift

  // Pin high impedance expected for an enable word
  function automatic logic [3:0] exp_hiz(input logic [3:0] e);
    return ~e;
  endfunction : exp_hiz

  task automatic chk(input string what, input logic [3:0] got, input logic [3:0] exp);
    checked++;
    if (got !== exp)
    begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic close_out();
    $display("comparisons %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : close_out

  // Bounded wait for a power-state value, cycles waited in n
  task automatic wait_ps(input logic [1:0] want, input int lim);
    n = 0;
    while (ps !== want && n < lim)
    begin
      @(negedge clk);
      n++;
    end
    if (ps !== want)
    begin
      err_count++;
      $display("[FAIL] power state wait expected %h seen %h", want, ps);
      close_out();
    end
  endtask : wait_ps

  // Main sequence
  initial
  begin
    nrst = 1'b0;
    ana = 1'b1;
    io = 1'b0;
    seed = 64'h40;
    err_count = 0;
    checked = 0;
    repeat (12) @(negedge clk);
    nrst = 1'b1;
    repeat (6) @(negedge clk);
    chk("shutdown serial", {3'h0, ser_en}, 4'h0);
    chk("shutdown hiz", hiz, 4'hF);
    $display("shutdown test done");
    io = 1'b1;
    repeat (8) @(negedge clk);
    chk("startup ctl", {1'b0, ser_en, bst_en, ser_rst}, 4'h7);
    chk("startup code", {2'h0, ps}, {2'h0, PWR_STARTUP});
    wait_ps(PWR_ACTIVE, 2 * SU);
    chk("startup time", {3'h0, n + 8 <= SU * STARTUP_MAX_US / STARTUP_TYP_US}, 4'h1);
    chk("default level", lvl, BOOST_LEVEL_RST);
    chk("default enables", en, OUT_EN_RST);
    chk("active ctl", {2'h0, ser_rst, bst_en}, 4'h1);
    u_host.select(2'h3);
    chk("unmapped read", rdata, 4'h0);
    for (int i = 0; i < 6; i++)
    begin
      seed = xorshift(seed);
      en_v = (i == 0) ? 4'hF : seed[3:0];
      lvl_v = seed[7:4];
      u_host.send_write(SEL_BOOST, lvl_v);
      u_host.send_write(SEL_OUT_EN, en_v);
      chk("dac enable", en, en_v);
      chk("hiz", hiz, exp_hiz(en_v));
      u_host.select(SEL_BOOST);
      chk("level read", rdata, lvl_v);
    end
    $display("active test done");
    u_host.send_write(SEL_POWER, {2'h0, PWR_LOWPOWER});
    chk("lp code", {2'h0, ps}, {2'h0, PWR_LOWPOWER});
    chk("lp ctl", {2'h0, bst_en, ser_en}, 4'h1);
    chk("lp hiz", hiz, 4'hF);
    u_host.send_write(SEL_POWER, {2'h0, PWR_LOWPOWER});
    u_host.send_write(SEL_POWER, 4'h3);
    repeat (10) @(negedge clk);
    chk("lp stays", {2'h0, ps}, {2'h0, PWR_LOWPOWER});
    chk("lp keeps level", lvl, lvl_v);
    u_host.send_write(SEL_POWER, {2'h0, PWR_ACTIVE});
    chk("lp exit", {2'h0, ps}, {2'h0, PWR_ACTIVE});
    chk("lp keeps enables", en, en_v);
    $display("low power test done");
    u_host.send_write(SEL_POWER, {2'h0, PWR_STARTUP});
    chk("restart code", {2'h0, ps}, {2'h0, PWR_STARTUP});
    chk("restart level", lvl, BOOST_LEVEL_RST);
    u_host.send_write(SEL_POWER, {2'h0, PWR_LOWPOWER});
    chk("startup ignores cmd", {2'h0, ps}, {2'h0, PWR_STARTUP});
    u_host.send_write(SEL_BOOST, 4'h2);
    chk("startup holds level", lvl, BOOST_LEVEL_RST);
    wait_ps(PWR_ACTIVE, 2 * SU);
    chk("restart enables", en, OUT_EN_RST);
    u_host.send_write(SEL_BOOST, 4'h2);
    io = 1'b0;
    repeat (8) @(negedge clk);
    chk("io low serial", {3'h0, ser_en}, 4'h0);
    chk("io low level", lvl, BOOST_LEVEL_RST);
    io = 1'b1;
    repeat (8) @(negedge clk);
    wait_ps(PWR_ACTIVE, 2 * SU);
    chk("second power-up", {3'h0, ser_en}, 4'h1);
    ana = 1'b0;
    repeat (8) @(negedge clk);
    chk("analog low serial", {3'h0, ser_en}, 4'h0);
    chk("analog low hiz", hiz, 4'hF);
    $display("supply test done");
    close_out();
  end
endmodule : tb_top

// ### design/pms_level_sync.sv
`timescale 1ns/1ps
// Three-stage synchroniser; output changes once stages two and three agree
module pms_level_sync (
  // Clock and reset
  input  wire logic sys_clk_i,
  input  wire logic rst_n_i,
  // Level in and out
  input  wire logic async_i,
  output logic      sync_o
);
  logic s1_q;
  logic s2_q;
  logic s3_q;
  logic out_q;

  // Shift chain
  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
    end
    else
    begin
      s1_q <= async_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // Accept a change only when two later stages agree
  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      out_q <= 1'b0;
    else if (s2_q == s3_q)
      out_q <= s3_q;
  end

  assign sync_o = out_q;
endmodule : pms_level_sync

// ### design/pms_pkg.sv
package pms_pkg;

  // Power-state field encodings
  localparam logic [1:0] PWR_ACTIVE   = 2'h0;
  localparam logic [1:0] PWR_STARTUP  = 2'h1;
  localparam logic [1:0] PWR_LOWPOWER = 2'h2;

  // Register reset values
  localparam logic [3:0] BOOST_LEVEL_RST = 4'hD;
  localparam logic [1:0] POWER_STATE_RST = PWR_STARTUP;
  localparam logic [3:0] OUT_EN_RST      = 4'h0;

  // Register selectors on the serial front-end write/read port
  localparam logic [1:0] SEL_BOOST   = 2'h0;
  localparam logic [1:0] SEL_POWER   = 2'h1;
  localparam logic [1:0] SEL_OUT_EN  = 2'h2;

  // Field widths
  localparam int BOOST_W = 4;
  localparam int PWR_W   = 2;
  localparam int NOUT    = 4;

  // Startup timing
  localparam int CLK_MHZ         = 100;
  localparam int STARTUP_TYP_US  = 180;
  localparam int STARTUP_MAX_US  = 250;
  localparam int STARTUP_CYCLES  = STARTUP_TYP_US * CLK_MHZ;
  localparam int STARTUP_MAX_CYC = STARTUP_MAX_US * CLK_MHZ;

  // Operating modes
  typedef enum logic [1:0] {
    PMS_SHUTDOWN,
    PMS_STARTUP,
    PMS_ACTIVE,
    PMS_LOWPOWER
  } pms_mode_e;

endpackage : pms_pkg

// ### design/pms_power_mode_sequencer.sv
`timescale 1ns/1ps
// Notes on behaviour
// - Analog supply low or IO supply low forces shutdown; outputs high impedance.
// - Registers are lost in shutdown; they are cleared to defaults.
// - IO supply high enters startup: defaults, serial on, boost on, outputs off.
// - Startup ends by itself and moves to active.
// - Host command from active or low power returns to startup, full reset.
// - Active runs everything; each output enabled separately by its enable bit.
// - Low power leaves to active only on the host command.
// - Low power: serial on, boost off, outputs high impedance.
// - Low power entered from active on the host command.
// - Registers keep their contents in low power.
// - IO-supply reset also resets the serial interface state machine.
// - IO-supply reset fires only on a rising edge of the supply level.
// - Power-state field reads startup code, then active code automatically.
// - Output enables are zero after the IO-supply reset.
// - Shutdown to active takes at most 250 us, typically 180 us.
// - Boost level is four bits, default gives a 28 V rail.
module pms_power_mode_sequencer
  import pms_pkg::*;
#(
  parameter int STARTUP_CYC = pms_pkg::STARTUP_CYCLES
) (
  // Clock and reset
  input  wire logic                        sys_clk_i,
  input  wire logic                        nrst_i,
  // Supply levels
  input  wire logic                        analog_supply_i,
  input  wire logic                        io_supply_level_i,
  // Serial front-end register port
  input  wire logic                        reg_wr_i,
  input  wire logic [1:0]                  reg_sel_i,
  input  wire logic [pms_pkg::BOOST_W-1:0] reg_wdata_i,
  output logic      [pms_pkg::BOOST_W-1:0] reg_rdata_o,
  // Mode controls
  output logic                             serial_enable_o,
  output logic                             serial_reset_o,
  output logic                             boost_enable_o,
  output logic      [pms_pkg::BOOST_W-1:0] boost_level_o,
  output logic      [pms_pkg::NOUT-1:0]    dac_enable_o,
  output logic      [pms_pkg::NOUT-1:0]    out_hiz_o,
  output logic      [pms_pkg::PWR_W-1:0]   power_state_o
);
  import pms_pkg::*;

  logic                rst_s1_q;
  logic                rst_n_q;
  logic                io_lvl;
  logic                ana_lvl;
  logic                io_prev_q;
  logic                io_rise;
  logic                supply_ok;
  logic                tmr_done;
  logic                run_startup;
  pms_mode_e           mode_q;
  pms_mode_e           mode_d;
  logic [BOOST_W-1:0]  boost_level_q;
  logic [NOUT-1:0]     out_en_q;
  logic [PWR_W-1:0]    power_state_q;
  logic                cmd_wr;
  logic [PWR_W-1:0]    cmd_code;
  logic                cmd_startup;
  logic                cmd_active;
  logic                cmd_lowpower;
  logic                wr_boost;
  logic                wr_out_en;
  logic                cfg_clear;
  logic [BOOST_W-1:0]  rdata_q;
  logic                serial_en_q;
  logic                serial_rst_q;
  logic                boost_en_q;
  logic [NOUT-1:0]     dac_en_q;
  logic [NOUT-1:0]     hiz_q;
  logic                drive_ok;
  logic [NOUT-1:0]     dac_en_d;

  // Reset release through two flip-flops
  always_ff @(posedge sys_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      rst_s1_q <= 1'b0;
      rst_n_q  <= 1'b0;
    end
    else
    begin
      rst_s1_q <= 1'b1;
      rst_n_q  <= rst_s1_q;
    end
  end

  // Supply pins synchronised
  pms_level_sync u_sync_io (
    .sys_clk_i (sys_clk_i),
    .rst_n_i   (rst_n_q),
    .async_i   (io_supply_level_i),
    .sync_o    (io_lvl)
  );

  pms_level_sync u_sync_ana (
    .sys_clk_i (sys_clk_i),
    .rst_n_i   (rst_n_q),
    .async_i   (analog_supply_i),
    .sync_o    (ana_lvl)
  );

  // Rising edge of the IO supply is the only trigger from shutdown into startup
  always_ff @(posedge sys_clk_i or negedge rst_n_q)
  begin
    if (!rst_n_q)
      io_prev_q <= 1'b0;
    else
      io_prev_q <= io_lvl;
  end

  assign supply_ok = ana_lvl & io_lvl;
  assign io_rise   = supply_ok & io_lvl & ~io_prev_q;

  // Startup interval timer
  assign run_startup = (mode_q == PMS_STARTUP);

  pms_startup_timer #(
    .CYCLES (STARTUP_CYC)
  ) u_timer (
    .sys_clk_i (sys_clk_i),
    .rst_n_i   (rst_n_q),
    .run_i     (run_startup),
    .done_o    (tmr_done)
  );

  // Write strobe for one register selector; nothing lands while the serial side is down
  function automatic logic wr_hit(
    input logic       en,
    input logic       wr,
    input logic [1:0] sel,
    input logic [1:0] target
  );
    return en && wr && (sel == target);
  endfunction : wr_hit

  // Decode of the host's register writes
  // Power-state writes are mode commands; the field itself mirrors the mode
  assign cmd_wr       = wr_hit(serial_en_q, reg_wr_i, reg_sel_i, SEL_POWER);
  assign wr_boost     = wr_hit(serial_en_q, reg_wr_i, reg_sel_i, SEL_BOOST);
  assign wr_out_en    = wr_hit(serial_en_q, reg_wr_i, reg_sel_i, SEL_OUT_EN);
  assign cmd_code     = reg_wdata_i[PWR_W-1:0];
  assign cmd_startup  = cmd_wr & (cmd_code == PWR_STARTUP);
  assign cmd_active   = cmd_wr & (cmd_code == PWR_ACTIVE);
  assign cmd_lowpower = cmd_wr & (cmd_code == PWR_LOWPOWER);

  // Next mode
  always_comb
  begin
    mode_d = mode_q;
    unique case (mode_q)
      PMS_SHUTDOWN:
        if (io_rise)
          mode_d = PMS_STARTUP;
      PMS_STARTUP:
        if (tmr_done)
          mode_d = PMS_ACTIVE;
      PMS_ACTIVE:
        if (cmd_startup)
          mode_d = PMS_STARTUP;
        else if (cmd_lowpower)
          mode_d = PMS_LOWPOWER;
      PMS_LOWPOWER:
        if (cmd_startup)
          mode_d = PMS_STARTUP;
        else if (cmd_active)
          mode_d = PMS_ACTIVE;
    endcase
    if (!supply_ok)
      mode_d = PMS_SHUTDOWN;
  end

  // Mode register
  always_ff @(posedge sys_clk_i or negedge rst_n_q)
  begin
    if (!rst_n_q)
      mode_q <= PMS_SHUTDOWN;
    else
      mode_q <= mode_d;
  end

  // Configuration is cleared in shutdown and whenever the next mode is startup
  assign cfg_clear = (mode_q == PMS_SHUTDOWN) || (mode_d == PMS_STARTUP);

  // Boost level register
  always_ff @(posedge sys_clk_i or negedge rst_n_q)
  begin
    if (!rst_n_q)
      boost_level_q <= BOOST_LEVEL_RST;
    else if (cfg_clear)
      boost_level_q <= BOOST_LEVEL_RST;
    else if (wr_boost)
      boost_level_q <= reg_wdata_i;
  end

  // Output enable register; one bit per output
  always_ff @(posedge sys_clk_i or negedge rst_n_q)
  begin
    if (!rst_n_q)
      out_en_q <= OUT_EN_RST;
    else if (cfg_clear)
      out_en_q <= OUT_EN_RST;
    else if (wr_out_en)
      out_en_q <= reg_wdata_i[NOUT-1:0];
  end

  // Power-state field follows the mode
  always_ff @(posedge sys_clk_i or negedge rst_n_q)
  begin
    if (!rst_n_q)
      power_state_q <= POWER_STATE_RST;
    else
    begin
      unique case (mode_d)
        PMS_ACTIVE:   power_state_q <= PWR_ACTIVE;
        PMS_LOWPOWER: power_state_q <= PWR_LOWPOWER;
        PMS_STARTUP,
        PMS_SHUTDOWN: power_state_q <= POWER_STATE_RST;
      endcase
    end
  end

  // Read data
  always_ff @(posedge sys_clk_i or negedge rst_n_q)
  begin
    if (!rst_n_q)
      rdata_q <= '0;
    else
    begin
      unique case (reg_sel_i)
        SEL_BOOST:  rdata_q <= boost_level_q;
        SEL_POWER:  rdata_q <= {{(BOOST_W-PWR_W){1'b0}}, power_state_q};
        SEL_OUT_EN: rdata_q <= out_en_q;
        default:    rdata_q <= '0;
      endcase
    end
  end

  // Serial side: usable in every mode but shutdown, held in reset until active
  always_ff @(posedge sys_clk_i or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      serial_en_q  <= 1'b0;
      serial_rst_q <= 1'b1;
    end
    else
    begin
      serial_en_q  <= (mode_d != PMS_SHUTDOWN);
      serial_rst_q <= (mode_d == PMS_SHUTDOWN) || (mode_d == PMS_STARTUP);
    end
  end

  // Boost runs from startup on and stops in low power and shutdown
  always_ff @(posedge sys_clk_i or negedge rst_n_q)
  begin
    if (!rst_n_q)
      boost_en_q <= 1'b0;
    else
      boost_en_q <= (mode_d == PMS_STARTUP) || (mode_d == PMS_ACTIVE);
  end

  // A stage may drive only in active mode, never on the edge that clears the enables
  assign drive_ok = (mode_d == PMS_ACTIVE) && !cfg_clear;

  // One enable bit per high-voltage stage
  for (genvar g = 0; g < NOUT; g++)
  begin : g_out
    assign dac_en_d[g] = drive_ok & out_en_q[g];
  end

  // Output stages; every stage that does not drive sits in high impedance
  always_ff @(posedge sys_clk_i or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      dac_en_q <= '0;
      hiz_q    <= '1;
    end
    else
    begin
      dac_en_q <= dac_en_d;
      hiz_q    <= ~dac_en_d;
    end
  end

  assign reg_rdata_o     = rdata_q;
  assign serial_enable_o = serial_en_q;
  assign serial_reset_o  = serial_rst_q;
  assign boost_enable_o  = boost_en_q;
  assign boost_level_o   = boost_level_q;
  assign dac_enable_o    = dac_en_q;
  assign out_hiz_o       = hiz_q;
  assign power_state_o   = power_state_q;
endmodule : pms_power_mode_sequencer

// ### design/pms_startup_timer.sv
`timescale 1ns/1ps
// Counts the startup interval and holds done high until run drops
module pms_startup_timer #(
  parameter int CYCLES = pms_pkg::STARTUP_CYCLES
) (
  // Clock and reset
  input  wire logic sys_clk_i,
  input  wire logic rst_n_i,
  // Control
  input  wire logic run_i,
  output logic      done_o
);
  localparam int CW = $clog2(CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

  logic [CW-1:0] cnt_q;
  logic          done_q;

  // Counter restarts whenever run drops
  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      cnt_q  <= '0;
      done_q <= 1'b0;
    end
    else if (!run_i)
    begin
      cnt_q  <= '0;
      done_q <= 1'b0;
    end
    else
    begin
      done_q <= (cnt_q == LAST);
      if (cnt_q != LAST)
        cnt_q <= cnt_q + CW'(1);
    end
  end

  assign done_o = done_q;
endmodule : pms_startup_timer
